// >>> clor_top.sv
// Listen-only receive path of a CAN controller with APB register access
`timescale 1ns/100ps
`default_nettype none
`include "clor_regs.svh"
module clor_top #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_valid,
  input wire logic frame_err,
  input wire logic [10:0] frame_id,
  input wire logic [3:0] frame_dlc,
  input wire logic [31:0] frame_data,
  input wire logic eng_tx_bit,
  input wire logic tx_err_evt,
  input wire logic tx_ok_evt,
  input wire logic rx_err_evt,
  input wire logic rx_ok_evt,
  output logic can_tx,
  output logic listen_only
);
  localparam int W = 52;

  generate
    if (FIFO_DEPTH < 2) begin : g_bad
      $error("clor_top: FIFO_DEPTH must be at least 2");
    end
  endgenerate

  // ==========================================
  // State and FIFO
  clor_pkg::clor_state_s st;
  clor_pkg::clor_state_s next_st;
  clor_stream_if #(.W(W)) in_s ();
  clor_stream_if #(.W(W)) out_s ();

  clor_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .wr_s(in_s),
    .rd_s(out_s)
  );

  // ==========================================
  // Acceptance filtering
  logic [15:0] match;
  logic match_any;
  logic [3:0] hit_idx;
  logic accept;
  logic push;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_filt
      logic [10:0] m;
      assign m = (gi < 8) ? st.mask0 : st.mask1;
      // Zero mask bits are don't-care, so an all-zero mask matches any id
      assign match[gi] = st.fen[gi] & (((frame_id ^ st.filt[gi]) & m) == 11'h000);
    end
  endgenerate

  always_comb begin
    hit_idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (match[i]) begin
        hit_idx = 4'(i);
      end
    end
  end

  assign match_any = |match;

  always_comb begin
    accept = 1'b0;
    unique case (st.mode)
      clor_pkg::CLOR_MODE_LISTEN: begin
        // Errored frames bypass filters and receive mode bits
        accept = frame_err | match_any;
      end
      clor_pkg::CLOR_MODE_NORMAL: begin
        accept = (st.rxm == `CLOR_RXM_ALL) | (~frame_err & match_any);
      end
      clor_pkg::CLOR_MODE_CFG: begin
        accept = 1'b0;
      end
    endcase
  end

  assign push = frame_valid & accept & in_s.ready;
  assign in_s.valid = frame_valid & accept;
  assign in_s.data = {frame_err, (frame_err & ~match_any) ? 4'h0 : hit_idx,
                      frame_dlc, frame_id, frame_data};

  // ==========================================
  // APB decode
  logic access;
  logic done;
  logic [13:0] idx;
  logic mapped;
  logic wr_done;
  logic [31:0] rd_val;
  logic [2:0] req;

  assign access = psel & penable;
  assign done = access & st.pready;
  assign idx = paddr[15:2];
  assign mapped = (paddr[1:0] == 2'h0) &&
                  ((idx >= `CLOR_IDX_CTRL && idx <= `CLOR_IDX_RX_DATA) ||
                   (idx >= `CLOR_IDX_FILT_BASE && idx <= `CLOR_IDX_FILT_LAST));
  assign wr_done = done & pwrite & mapped;
  assign req = pwdata[`CLOR_CTRL_REQ_HI:`CLOR_CTRL_REQ_LO];
  // Reading the data word releases the head entry
  assign out_s.ready = done & ~pwrite & mapped & (idx == `CLOR_IDX_RX_DATA);

  always_comb begin
    rd_val = 32'h0000_0000;
    if (idx >= `CLOR_IDX_FILT_BASE) begin
      rd_val = {21'h0, st.filt[idx[3:0]]};
    end else begin
      unique case (idx)
        `CLOR_IDX_CTRL: rd_val = {24'h0, 1'b0, st.mode == clor_pkg::CLOR_MODE_CFG,
                                  st.mode == clor_pkg::CLOR_MODE_LISTEN, 5'h00};
        `CLOR_IDX_STATUS: rd_val = {29'h0, st.ovf, st.mode};
        `CLOR_IDX_ERRCNT: rd_val = {16'h0, st.rec, st.tec};
        `CLOR_IDX_RXMODE: rd_val = {30'h0, st.rxm};
        `CLOR_IDX_MASK0: rd_val = {21'h0, st.mask0};
        `CLOR_IDX_MASK1: rd_val = {21'h0, st.mask1};
        `CLOR_IDX_FEN_LOW: rd_val = {24'h0, st.fen[7:0]};
        `CLOR_IDX_FEN_HIGH: rd_val = {24'h0, st.fen[15:8]};
        `CLOR_IDX_RX_ID: rd_val = {out_s.valid, 11'h0, out_s.data[W-1:32]};
        `CLOR_IDX_RX_DATA: rd_val = out_s.data[31:0];
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // Next state
  always_comb begin
    next_st = st;
    // One wait state: pready rises in the second access cycle
    next_st.pready = access & ~st.pready;
    next_st.pslverr = access & ~st.pready & ~mapped;
    next_st.prdata = (access & ~st.pready & ~pwrite & mapped) ? rd_val : 32'h0000_0000;

    if (wr_done) begin
      if (idx >= `CLOR_IDX_FILT_BASE) begin
        next_st.filt[idx[3:0]] = pwdata[10:0];
      end else begin
        unique case (idx)
          `CLOR_IDX_CTRL: begin
            case (req)
              `CLOR_REQ_NORMAL: next_st.mode = clor_pkg::CLOR_MODE_NORMAL;
              `CLOR_REQ_LISTEN: next_st.mode = clor_pkg::CLOR_MODE_LISTEN;
              `CLOR_REQ_CONFIG: next_st.mode = clor_pkg::CLOR_MODE_CFG;
              default: next_st.mode = st.mode;
            endcase
          end
          `CLOR_IDX_STATUS: begin
            if (pwdata[`CLOR_STAT_OVF]) begin
              next_st.ovf = 1'b0;
            end
          end
          `CLOR_IDX_RXMODE: next_st.rxm = pwdata[1:0];
          `CLOR_IDX_MASK0: next_st.mask0 = pwdata[10:0];
          `CLOR_IDX_MASK1: next_st.mask1 = pwdata[10:0];
          `CLOR_IDX_FEN_LOW: next_st.fen[7:0] = pwdata[7:0];
          `CLOR_IDX_FEN_HIGH: next_st.fen[15:8] = pwdata[7:0];
          default: next_st.rxm = st.rxm;
        endcase
      end
    end

    // Drop on full; set placed after the clear so it wins
    if (in_s.valid & ~in_s.ready) begin
      next_st.ovf = 1'b1;
    end

    // Error counters, saturating
    if (tx_err_evt) begin
      next_st.tec = (st.tec > 8'hf7) ? 8'hff : st.tec + `CLOR_TEC_ERR_STEP;
    end else if (tx_ok_evt && st.tec != 8'h00) begin
      next_st.tec = st.tec - 8'h01;
    end
    if (rx_err_evt && st.rec != 8'hff) begin
      next_st.rec = st.rec + 8'h01;
    end else if (rx_ok_evt && st.rec != 8'h00) begin
      next_st.rec = st.rec - 8'h01;
    end
    // Held at zero from the entry edge onward
    if (next_st.mode == clor_pkg::CLOR_MODE_LISTEN) begin
      next_st.tec = 8'h00;
      next_st.rec = 8'h00;
    end

    // Only normal mode may drive dominant bits, acks and error flags included
    next_st.can_tx = (next_st.mode != clor_pkg::CLOR_MODE_NORMAL) | eng_tx_bit;
    next_st.listen_only = (next_st.mode == clor_pkg::CLOR_MODE_LISTEN);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= '0;
      st.mode <= clor_pkg::CLOR_MODE_CFG;
      st.rxm <= `CLOR_RXM_RESET;
      st.mask0 <= `CLOR_MASK_RESET;
      st.mask1 <= `CLOR_MASK_RESET;
      st.fen <= {`CLOR_FEN_RESET, `CLOR_FEN_RESET};
      st.can_tx <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign can_tx = st.can_tx;
  assign listen_only = st.listen_only;

  // ==========================================
  // Assertions
  AST_SILENT: assert property (@(posedge clock) disable iff (!nrst)
    st.mode == clor_pkg::CLOR_MODE_LISTEN |-> can_tx)
    else $error("bus driven dominant in listen-only mode");

  AST_NOT_NORMAL_RECESSIVE: assert property (@(posedge clock) disable iff (!nrst)
    st.mode != clor_pkg::CLOR_MODE_NORMAL |-> can_tx)
    else $error("bus driven dominant outside normal mode");

  AST_RESET_OUT: assert property (@(posedge clock)
    nrst && !$past(nrst) |-> !pready && !pslverr && prdata == 32'h0000_0000
    && can_tx && !listen_only)
    else $error("outputs not at reset values after reset");

  AST_ERRCNT_HELD: assert property (@(posedge clock) disable iff (!nrst)
    st.mode == clor_pkg::CLOR_MODE_LISTEN |-> st.tec == 8'h00 && st.rec == 8'h00)
    else $error("error counter nonzero in listen-only mode");

  AST_ERRCNT_ENTRY: assert property (@(posedge clock) disable iff (!nrst)
    wr_done && idx == `CLOR_IDX_CTRL && req == `CLOR_REQ_LISTEN
    |=> st.tec == 8'h00 && st.rec == 8'h00)
    else $error("error counters not cleared on entry");

  AST_ENTER: assert property (@(posedge clock) disable iff (!nrst)
    done && pwrite && paddr == {`CLOR_IDX_CTRL, 2'b00} && req == `CLOR_REQ_LISTEN
    |=> st.mode == clor_pkg::CLOR_MODE_LISTEN && listen_only)
    else $error("listen-only request not taken");

  AST_LISTEN_LEVEL: assert property (@(posedge clock) disable iff (!nrst)
    listen_only == (st.mode == clor_pkg::CLOR_MODE_LISTEN))
    else $error("listen-only flag disagrees with mode");

  AST_ERR_FRAME: assert property (@(posedge clock) disable iff (!nrst)
    st.mode == clor_pkg::CLOR_MODE_LISTEN && frame_valid && frame_err && in_s.ready
    |-> push ##1 out_s.valid)
    else $error("errored frame not received in listen-only mode");

  AST_ERR_RXM: assert property (@(posedge clock) disable iff (!nrst)
    st.mode == clor_pkg::CLOR_MODE_LISTEN && st.rxm != `CLOR_RXM_ALL && frame_valid
    && frame_err && !match_any && in_s.ready |-> push)
    else $error("errored frame refused by mode or filters");

  AST_ERR_NOFILT: assert property (@(posedge clock) disable iff (!nrst)
    st.mode == clor_pkg::CLOR_MODE_LISTEN && frame_valid && frame_err && st.fen == 16'h0000
    && !in_s.ready |=> st.ovf)
    else $error("errored frame lost without overflow");

  AST_VALID_FILT: assert property (@(posedge clock) disable iff (!nrst)
    st.mode == clor_pkg::CLOR_MODE_LISTEN && frame_valid && !frame_err && !match_any
    |-> !push && !in_s.valid)
    else $error("unmatched valid frame stored in listen-only mode");

  AST_VALID_MATCH: assert property (@(posedge clock) disable iff (!nrst)
    st.mode == clor_pkg::CLOR_MODE_LISTEN && frame_valid && !frame_err && match_any
    && in_s.ready |-> push)
    else $error("matching valid frame not stored in listen-only mode");

  AST_MASK_ZERO: assert property (@(posedge clock) disable iff (!nrst)
    st.mode == clor_pkg::CLOR_MODE_LISTEN && st.mask0 == 11'h000 && st.fen[0]
    && frame_valid && !frame_err && in_s.ready |-> push && in_s.data[50:47] == 4'h0)
    else $error("zero mask did not pass frame");

  AST_CFG_NO_STORE: assert property (@(posedge clock) disable iff (!nrst)
    st.mode == clor_pkg::CLOR_MODE_CFG |-> !in_s.valid)
    else $error("frame offered to the FIFO in configuration mode");

  AST_DROP_OVF: assert property (@(posedge clock) disable iff (!nrst)
    in_s.valid && !in_s.ready |=> st.ovf)
    else $error("dropped frame did not set overflow");

  AST_MAP_HIGH: assert property (@(posedge clock) disable iff (!nrst)
    done && !pwrite && paddr == {`CLOR_IDX_FEN_HIGH, 2'b00}
    |-> prdata == {24'h0, st.fen[15:8]} && !pslverr)
    else $error("high filter enable not at its index");

  AST_MAP_LOW: assert property (@(posedge clock) disable iff (!nrst)
    done && pwrite && paddr == {`CLOR_IDX_FEN_LOW, 2'b00}
    |=> st.fen[7:0] == $past(pwdata[7:0]) && $stable(st.fen[15:8]))
    else $error("low filter enable not at its index");

  AST_UNMAPPED: assert property (@(posedge clock) disable iff (!nrst)
    done && !mapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  AST_PREADY_PULSE: assert property (@(posedge clock) disable iff (!nrst)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  AST_PRDATA_IDLE: assert property (@(posedge clock) disable iff (!nrst)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data nonzero outside a completing read");

  // ==========================================
  // Coverage of the main scenarios
  COV_ENTER: cover property (@(posedge clock) disable iff (!nrst)
    $rose(st.listen_only));

  COV_ERR_STORED: cover property (@(posedge clock) disable iff (!nrst)
    st.mode == clor_pkg::CLOR_MODE_LISTEN && push && frame_err);

  COV_OVERFLOW: cover property (@(posedge clock) disable iff (!nrst)
    $rose(st.ovf));

  COV_POP: cover property (@(posedge clock) disable iff (!nrst)
    out_s.ready && out_s.valid);

  COV_HIT_HIGH: cover property (@(posedge clock) disable iff (!nrst)
    push && !frame_err && hit_idx[3]);
endmodule
`default_nettype wire

// >>> clor_regs.svh
// Register indices, field positions, reset values and codes of the listen-only receive block
//
// Behaviour
// - In listen-only mode every frame seen on the bus goes to reception, errored ones included; the code stores valid frames only on a filter match.
// - In listen-only mode the block keeps the bus recessive: no frames, error flags or acks.
// - In listen-only mode valid and errored frames are received whatever the receive mode bits.
// - In listen-only mode valid frames still pass the filters and masks, only matches are stored.
// - With all mask bits zero a valid frame of any identifier passes an enabled filter.
// - In listen-only mode errored frames are stored even if filters, masks or mode would reject.
// - Entering listen-only mode clears both error counters, which stay at zero while in it.
// - Writing the listen-only code into the mode request field of the control register enters it.
// - The high filter enable register sits at index e47h and the low one at index e46h.
`ifndef CLOR_REGS_SVH
`define CLOR_REGS_SVH

// ==========================================
// Register indices (byte address = 4 x index)
`define CLOR_IDX_CTRL 14'he40
`define CLOR_IDX_STATUS 14'he41
`define CLOR_IDX_ERRCNT 14'he42
`define CLOR_IDX_RXMODE 14'he43
`define CLOR_IDX_MASK0 14'he44
`define CLOR_IDX_MASK1 14'he45
`define CLOR_IDX_FEN_LOW 14'he46
`define CLOR_IDX_FEN_HIGH 14'he47
`define CLOR_IDX_RX_ID 14'he48
`define CLOR_IDX_RX_DATA 14'he49
`define CLOR_IDX_FILT_BASE 14'he50
`define CLOR_IDX_FILT_LAST 14'he5f

// ==========================================
// Control fields and codes
`define CLOR_CTRL_REQ_HI 7
`define CLOR_CTRL_REQ_LO 5
`define CLOR_REQ_NORMAL 3'h0
`define CLOR_REQ_LISTEN 3'h3
`define CLOR_REQ_CONFIG 3'h4
`define CLOR_RXM_ALL 2'h3
`define CLOR_STAT_OVF 2

// ==========================================
// Reset values
`define CLOR_FEN_RESET 8'h00
`define CLOR_MASK_RESET 11'h7ff
`define CLOR_RXM_RESET 2'h0

// ==========================================
// Receive word layout and transmit error counter step
`define CLOR_W_ERR 51
`define CLOR_W_HIT_HI 50
`define CLOR_W_HIT_LO 47
`define CLOR_W_DLC_HI 46
`define CLOR_W_DLC_LO 43
`define CLOR_W_ID_HI 42
`define CLOR_W_ID_LO 32
`define CLOR_TEC_ERR_STEP 8'h08

`endif

// >>> clor_pkg.sv
// Types of the listen-only receive block
`default_nettype none
package clor_pkg;
  typedef enum logic [1:0] {
    CLOR_MODE_CFG = 2'b00,
    CLOR_MODE_NORMAL = 2'b01,
    CLOR_MODE_LISTEN = 2'b11
  } clor_mode_e;

  typedef struct packed {
    clor_mode_e mode;
    logic [1:0] rxm;
    logic [10:0] mask0;
    logic [10:0] mask1;
    logic [15:0] fen;
    logic [15:0][10:0] filt;
    logic [7:0] tec;
    logic [7:0] rec;
    logic ovf;
    logic can_tx;
    logic listen_only;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } clor_state_s;
endpackage
`default_nettype wire

// >>> clor_stream_if.sv
// Valid/ready word stream between the block and its receive FIFO
`timescale 1ns/100ps
`default_nettype none
interface clor_stream_if #(parameter int W = 52);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport sink (input valid, input data, output ready);
  modport source (output valid, output data, input ready);
endinterface
`default_nettype wire

// >>> clor_fifo.sv
// Receive FIFO with parameterised width and depth
`timescale 1ns/100ps
`default_nettype none
module clor_fifo #(
  parameter int W = 52,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  clor_stream_if.sink wr_s,
  clor_stream_if.source rd_s
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
      $error("clor_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } clor_fifo_s;

  clor_fifo_s st;
  clor_fifo_s next_st;
  logic push;
  logic pop;

  // Full and empty come from the registered count only
  assign wr_s.ready = (st.cnt != (AW+1)'(DEPTH));
  assign rd_s.valid = (st.cnt != '0);
  assign rd_s.data = st.mem[st.rd];
  assign push = wr_s.valid & wr_s.ready;
  assign pop = rd_s.valid & rd_s.ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = wr_s.data;
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// >>> clor_node_model.sv
// Model of the other bus nodes as seen through the protocol engine
`timescale 1ns/100ps
`default_nettype none
module clor_node_model (
  input wire logic clock,
  output logic frame_valid,
  output logic frame_err,
  output logic [10:0] frame_id,
  output logic [3:0] frame_dlc,
  output logic [31:0] frame_data,
  output logic eng_tx_bit,
  output logic [3:0] evt
);
  initial begin
    frame_valid = 1'b0;
    frame_err = 1'b0;
    frame_id = 11'h000;
    frame_dlc = 4'h0;
    frame_data = 32'h00000000;
    eng_tx_bit = 1'b1;
    evt = 4'h0;
  end

  // Engine keeps asking for dominant bits, so silence must come from the block
  always @(posedge clock) begin
    eng_tx_bit <= ~eng_tx_bit;
  end

  // Back-to-back frame ends; qualifiers are scrambled once the pulse is gone
  task automatic send_burst(input int n, input logic err, input logic [10:0] id0);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      frame_valid <= 1'b1;
      frame_err <= err;
      frame_id <= id0 + 11'(i);
      frame_dlc <= 4'h8;
      frame_data <= {21'h0, id0 + 11'(i)};
    end
    @(posedge clock);
    frame_valid <= 1'b0;
    frame_err <= ~err;
    frame_id <= ~frame_id;
    frame_dlc <= ~frame_dlc;
    frame_data <= ~frame_data;
  endtask

  // Bit order: tx error, tx ok, rx error, rx ok
  task automatic pulse(input logic [3:0] which);
    @(posedge clock);
    evt <= which;
    @(posedge clock);
    evt <= 4'h0;
  endtask
endmodule
`default_nettype wire

// >>> clor_top_tb.sv
// Self-checking testbench of the listen-only receive block
`timescale 1ns/100ps
`default_nettype none
`include "clor_regs.svh"
module clor_top_tb;
  localparam int DEPTH = 4;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic frame_valid, frame_err, eng_tx_bit, can_tx, listen_only;
  logic [10:0] frame_id;
  logic [3:0] frame_dlc, evt;
  logic [31:0] frame_data;
  int bad_count, cmp_count;

  clor_top #(.FIFO_DEPTH(DEPTH)) DUT (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid), .frame_err(frame_err),
    .frame_id(frame_id), .frame_dlc(frame_dlc), .frame_data(frame_data),
    .eng_tx_bit(eng_tx_bit), .tx_err_evt(evt[3]), .tx_ok_evt(evt[2]), .rx_err_evt(evt[1]),
    .rx_ok_evt(evt[0]), .can_tx(can_tx), .listen_only(listen_only));

  clor_node_model node (.clock(clock), .frame_valid(frame_valid), .frame_err(frame_err),
    .frame_id(frame_id), .frame_dlc(frame_dlc), .frame_data(frame_data),
    .eng_tx_bit(eng_tx_bit), .evt(evt));

  always #20 clock = ~clock;

  // ==========================================
  // Shared tasks
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) cmp32(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_chk(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    cmp32(rd, exp);
  endtask

  task automatic empty_chk;
    apb(1'b0, `CLOR_IDX_RX_ID, 32'h0);
    cmp32({31'h0, rd[31]}, 32'h0);
  endtask

  task automatic rx_chk(input logic [10:0] id, input logic err, input logic [3:0] hit);
    reg_chk(`CLOR_IDX_RX_ID, {1'b1, 11'h000, err, hit, 4'h8, id});
    reg_chk(`CLOR_IDX_RX_DATA, {21'h0, id});
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs;
    reg_chk(`CLOR_IDX_FEN_LOW, 32'h0);
    reg_chk(`CLOR_IDX_FEN_HIGH, 32'h0);
    apb(1'b1, `CLOR_IDX_FEN_LOW, 32'ha5);
    apb(1'b1, `CLOR_IDX_FEN_HIGH, 32'h3c);
    reg_chk(`CLOR_IDX_FEN_LOW, 32'ha5);
    reg_chk(`CLOR_IDX_FEN_HIGH, 32'h3c);
    apb(1'b0, 14'h0100, 32'h0);
    cmp32({31'h0, er}, 32'h1);
    apb(1'b1, `CLOR_IDX_FEN_LOW, 32'h0);
    apb(1'b1, `CLOR_IDX_FEN_HIGH, 32'h0);
  endtask

  task automatic t_counters;
    apb(1'b1, `CLOR_IDX_CTRL, 32'h0);
    node.pulse(4'ha);
    reg_chk(`CLOR_IDX_ERRCNT, 32'h0108);
    apb(1'b1, `CLOR_IDX_CTRL, 32'h60);
    reg_chk(`CLOR_IDX_ERRCNT, 32'h0);
    apb(1'b0, `CLOR_IDX_STATUS, 32'h0);
    cmp32({30'h0, rd[1:0]}, 32'h3);
    cmp32({31'h0, listen_only}, 32'h1);
    node.pulse(4'ha);
    reg_chk(`CLOR_IDX_ERRCNT, 32'h0);
  endtask

  task automatic t_silent;
    repeat (8) begin
      @(negedge clock);
      cmp32({31'h0, can_tx}, 32'h1);
    end
  endtask

  task automatic t_frames;
    node.send_burst(1, 1'b1, 11'h123);
    rx_chk(11'h123, 1'b1, 4'h0);
    node.send_burst(1, 1'b0, 11'h155);
    empty_chk();
    apb(1'b1, `CLOR_IDX_FILT_BASE, 32'h155);
    apb(1'b1, `CLOR_IDX_FEN_LOW, 32'h1);
    node.send_burst(1, 1'b0, 11'h155);
    rx_chk(11'h155, 1'b0, 4'h0);
    node.send_burst(1, 1'b0, 11'h156);
    empty_chk();
    apb(1'b1, `CLOR_IDX_MASK0, 32'h0);
    node.send_burst(1, 1'b0, 11'h2aa);
    rx_chk(11'h2aa, 1'b0, 4'h0);
    apb(1'b1, `CLOR_IDX_FEN_LOW, 32'h0);
    apb(1'b1, `CLOR_IDX_FILT_BASE + 14'h0008, 32'h2ab);
    apb(1'b1, `CLOR_IDX_FEN_HIGH, 32'h1);
    node.send_burst(1, 1'b0, 11'h2ab);
    rx_chk(11'h2ab, 1'b0, 4'h8);
    apb(1'b1, `CLOR_IDX_RXMODE, 32'h3);
    node.send_burst(1, 1'b0, 11'h2ac);
    empty_chk();
    node.send_burst(1, 1'b1, 11'h2ad);
    rx_chk(11'h2ad, 1'b1, 4'h0);
  endtask

  // Overrun with the far side never pausing, then a full drain
  task automatic t_fifo;
    apb(1'b1, `CLOR_IDX_FEN_HIGH, 32'h0);
    node.send_burst(DEPTH + 1, 1'b1, 11'h300);
    apb(1'b0, `CLOR_IDX_STATUS, 32'h0);
    cmp32({31'h0, rd[2]}, 32'h1);
    for (int i = 0; i < DEPTH; i++) begin
      rx_chk(11'h300 + 11'(i), 1'b1, 4'h0);
    end
    empty_chk();
    apb(1'b1, `CLOR_IDX_STATUS, 32'h4);
    reg_chk(`CLOR_IDX_STATUS, 32'h3);
  endtask

  // Config request drops the listen-only flag and stores nothing
  task automatic t_config;
    apb(1'b1, `CLOR_IDX_CTRL, 32'h80);
    reg_chk(`CLOR_IDX_CTRL, 32'h40);
    cmp32({31'h0, listen_only}, 32'h0);
    node.send_burst(1, 1'b1, 11'h321);
    empty_chk();
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_counters();
    t_silent();
    t_frames();
    t_fifo();
    t_config();
    tally_and_finish();
  end

  initial begin
    #800000;
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
